//--- rtl/iap_pkg.sv
// constants, types and operation list for the flash programming controller
package iap_pkg;

    localparam logic [7:0]  ADDR_UPGRADE_STATUS   = 8'h21;
    localparam logic [7:0]  ADDR_REGION_JUMP      = 8'h22;
    localparam logic [7:0]  ADDR_CODE_OFFSET_LOW  = 8'h23;
    localparam logic [7:0]  ADDR_CODE_OFFSET_HIGH = 8'h24;
    localparam logic [7:0]  ADDR_PROG_HIGH        = 8'hf9;
    localparam logic [7:0]  ADDR_PROG_LOW         = 8'hfa;
    localparam logic [7:0]  ADDR_PROG_DATA        = 8'hfb;
    localparam logic [7:0]  ADDR_PROG_COMMAND     = 8'hfc;
    localparam logic [7:0]  ADDR_ERASE_TIMING     = 8'hfd;

    localparam logic [7:0]  RST_BYTE              = 8'h00;
    localparam logic [7:0]  RST_ERASE_TIMING      = 8'h5a;
    localparam logic [15:0] RST_CODE_OFFSET       = 16'h0000;

    localparam logic [7:0]  OP_ERASE              = 8'h96;
    localparam logic [7:0]  OP_PROGRAM            = 8'h69;
    localparam logic [39:0] KEY_ENTER             = 40'h12_3456_789a;
    localparam logic [39:0] KEY_EXIT              = 40'hfe_dcba_9876;
    localparam logic [39:0] KEY_TO_APP            = 40'hff_0088_55aa;
    localparam logic [39:0] KEY_TO_BOOT           = 40'h37_c842_9a65;
    localparam logic [2:0]  KEY_DONE              = 3'h5;

    localparam logic [15:0] CODE_OFFSET_APP       = 16'h1000;
    localparam logic [15:0] CODE_OFFSET_BOOT      = 16'h0000;
    localparam logic [15:0] BOOT_LIMIT            = 16'h1000;
    localparam logic [15:0] EEPROM_BLOCK0_BASE    = 16'h8400;
    localparam logic [15:0] EEPROM_BLOCK1_BASE    = 16'h8600;
    localparam logic [1:0]  BOOT_CFG_APP          = 2'h1;
    localparam logic [1:0]  BOOT_CFG_NONE         = 2'h3;

    localparam int          HIGH_EEPROM_SEL_BIT   = 7;
    localparam int          HIGH_BLOCK_BIT        = 2;
    localparam int          HIGH_ADDR8_BIT        = 0;
    localparam int          STATUS_UPGRADE_BIT    = 0;
    localparam int          TIM_ERASE_MSB         = 4;
    localparam logic [4:0]  ERASE_SEL_MAX         = 5'h09;

    localparam int          CLK_PERIOD_NS         = 50;
    localparam int          ERASE_STEP_NS         = 500000;
    localparam int          ERASE_BASE_NS         = 65000;
    localparam int          ERASE_LONG_NS         = 4565200;
    localparam int          PROGRAM_NS            = 23500;
    localparam int          ERASE_STEP_CYC  = (ERASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ERASE_BASE_CYC  = (ERASE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ERASE_LONG_CYC  = (ERASE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PROGRAM_CYC     = (PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W                 = 18;

    typedef enum logic [1:0] {
        NV_IDLE    = 2'b00,
        NV_ERASE   = 2'b01,
        NV_PROGRAM = 2'b10
    } nv_state_t;

endpackage

//--- rtl/flash_iap_boot_upgrade_ctrl.sv
// flash and data eeprom programming controller with boot upgrade keys
`timescale 1ns/1ns
module flash_iap_boot_upgrade_ctrl #(
    parameter int ERASE_STEP_CYCLES = iap_pkg::ERASE_STEP_CYC,
    parameter int ERASE_LONG_CYCLES = iap_pkg::ERASE_LONG_CYC
) (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    // special function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // secondary bus register port
    input  wire logic [7:0]  sec_addr,
    input  wire logic        sec_wr,
    input  wire logic [7:0]  sec_wdata,
    output logic      [7:0]  sec_rdata,
    // boot configuration and program fetch
    input  wire logic [1:0]  boot_sel,
    input  wire logic [15:0] pc,
    output logic      [15:0] fetch_addr,
    // nonvolatile array control
    output logic             nv_start,
    output logic             nv_erase,
    output logic             nv_flash,
    output logic      [15:0] nv_addr,
    output logic      [7:0]  nv_wdata,
    output logic             nv_busy,
    output logic             sys_clk_en
);
    import iap_pkg::*;

    // register state
    logic [7:0]  prog_address_high_q;
    logic [7:0]  prog_address_high_d;
    logic [7:0]  prog_address_low_q;
    logic [7:0]  prog_address_low_d;
    logic [7:0]  prog_write_data_q;
    logic [7:0]  prog_write_data_d;
    logic [7:0]  prog_command_q;
    logic [7:0]  prog_command_d;
    logic [7:0]  erase_timing_q;
    logic [7:0]  erase_timing_d;
    logic [7:0]  region_jump_q;
    logic [7:0]  region_jump_d;
    logic        upgrade_q;
    logic        upgrade_d;
    logic [15:0] code_offset_q;
    logic [15:0] code_offset_d;

    // key matchers
    logic [2:0]  enter_idx_q;
    logic [2:0]  enter_idx_d;
    logic [2:0]  exit_idx_q;
    logic [2:0]  exit_idx_d;
    logic [2:0]  app_idx_q;
    logic [2:0]  app_idx_d;
    logic [2:0]  boot_idx_q;
    logic [2:0]  boot_idx_d;

    // operation sequencer
    nv_state_t          state_q;
    nv_state_t          state_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   cnt_d;
    logic               nv_start_q;
    logic               nv_start_d;
    logic               nv_erase_q;
    logic               nv_erase_d;
    logic               nv_flash_q;
    logic               nv_flash_d;
    logic [15:0]        nv_addr_q;
    logic [15:0]        nv_addr_d;
    logic [7:0]         nv_wdata_q;
    logic [7:0]         nv_wdata_d;

    // read data and fetch address
    logic [7:0]  sfr_rdata_q;
    logic [7:0]  sfr_rdata_d;
    logic [7:0]  sec_rdata_q;
    logic [7:0]  sec_rdata_d;
    logic [15:0] fetch_addr_q;
    logic [15:0] fetch_addr_d;

    // decoded terms
    logic [15:0] offset_eff;
    logic [15:0] fetch_phys;
    logic        in_boot;
    logic        flash_target;
    logic [15:0] target_addr;
    logic        target_protected;
    logic        cmd_wr;
    logic        jump_wr;
    logic [2:0]  enter_nx;
    logic [2:0]  exit_nx;
    logic [2:0]  app_nx;
    logic [2:0]  boot_nx;

    // byte of a five-byte key at a given position
    function automatic logic [7:0] key_byte(input logic [39:0] key, input logic [2:0] idx);
        logic [7:0] b;
        b = key[39:32];
        unique case (idx)
            3'h0: b = key[39:32];
            3'h1: b = key[31:24];
            3'h2: b = key[23:16];
            3'h3: b = key[15:8];
            3'h4: b = key[7:0];
            default: b = key[39:32];
        endcase
        return b;
    endfunction

    // next matcher position; KEY_DONE means the whole key arrived
    function automatic logic [2:0] key_step(input logic [39:0] key, input logic [2:0] idx,
                                            input logic [7:0] data);
        logic [2:0] nx;
        nx = 3'h0;
        if (data == key_byte(key, idx)) begin
            nx = idx + 3'h1;
        end else if (data == key_byte(key, 3'h0)) begin
            nx = 3'h1;
        end
        return nx;
    endfunction

    // erase duration in cycles from the timing select field
    function automatic logic [CNT_W-1:0] erase_cycles(input logic [4:0] sel);
        logic [CNT_W-1:0] n;
        if (sel <= ERASE_SEL_MAX) begin
            n = CNT_W'(ERASE_BASE_CYC + (int'(sel) + 1) * ERASE_STEP_CYCLES);
        end else begin
            n = CNT_W'(ERASE_LONG_CYCLES);
        end
        return n;
    endfunction

    // address mapping, protection and fetch
    always_comb begin
        offset_eff = (boot_sel == BOOT_CFG_APP) ? CODE_OFFSET_APP : code_offset_q;
        fetch_phys = pc + offset_eff;
        in_boot    = (boot_sel != BOOT_CFG_NONE) && (fetch_phys < BOOT_LIMIT);
        flash_target = upgrade_q && !prog_address_high_q[HIGH_EEPROM_SEL_BIT];
        if (flash_target) begin
            target_addr = {prog_address_high_q, prog_address_low_q};
        end else begin
            target_addr = (prog_address_high_q[HIGH_BLOCK_BIT] ? EEPROM_BLOCK1_BASE
                                                                : EEPROM_BLOCK0_BASE)
                        | {7'h00, prog_address_high_q[HIGH_ADDR8_BIT],
                           prog_address_low_q};
        end
        target_protected = flash_target && (boot_sel != BOOT_CFG_NONE)
                         && (target_addr < BOOT_LIMIT);
        cmd_wr  = sfr_wr && (sfr_addr == ADDR_PROG_COMMAND) && (state_q == NV_IDLE);
        jump_wr = sec_wr && (sec_addr == ADDR_REGION_JUMP);
        enter_nx = key_step(KEY_ENTER, enter_idx_q, sfr_wdata);
        exit_nx  = key_step(KEY_EXIT, exit_idx_q, sfr_wdata);
        app_nx   = key_step(KEY_TO_APP, app_idx_q, sec_wdata);
        boot_nx  = key_step(KEY_TO_BOOT, boot_idx_q, sec_wdata);
    end

    // next values of registers, matchers and sequencer
    always_comb begin
        prog_address_high_d = prog_address_high_q;
        prog_address_low_d  = prog_address_low_q;
        prog_write_data_d   = prog_write_data_q;
        prog_command_d      = prog_command_q;
        erase_timing_d      = erase_timing_q;
        region_jump_d       = region_jump_q;
        upgrade_d           = upgrade_q;
        code_offset_d       = code_offset_q;
        enter_idx_d         = enter_idx_q;
        exit_idx_d          = exit_idx_q;
        app_idx_d           = app_idx_q;
        boot_idx_d          = boot_idx_q;
        state_d             = state_q;
        cnt_d               = cnt_q;
        nv_start_d          = 1'b0;
        nv_erase_d          = nv_erase_q;
        nv_flash_d          = nv_flash_q;
        nv_addr_d           = nv_addr_q;
        nv_wdata_d          = nv_wdata_q;
        fetch_addr_d        = fetch_phys;

        if (sfr_wr) begin
            unique case (sfr_addr)
                ADDR_PROG_HIGH:    prog_address_high_d = sfr_wdata;
                ADDR_PROG_LOW:     prog_address_low_d  = sfr_wdata;
                ADDR_PROG_DATA:    prog_write_data_d   = sfr_wdata;
                ADDR_ERASE_TIMING: erase_timing_d      = sfr_wdata;
                default: ;
            endcase
        end

        if (cmd_wr) begin
            prog_command_d = sfr_wdata;
            enter_idx_d = (enter_nx == KEY_DONE) ? 3'h0 : enter_nx;
            exit_idx_d  = (exit_nx == KEY_DONE) ? 3'h0 : exit_nx;
            if (enter_nx == KEY_DONE && boot_sel != BOOT_CFG_NONE && in_boot) begin
                upgrade_d = 1'b1;
            end
            if (exit_nx == KEY_DONE) begin
                upgrade_d = 1'b0;
            end
            if ((sfr_wdata == OP_ERASE || sfr_wdata == OP_PROGRAM)
                && !target_protected) begin
                nv_start_d = 1'b1;
                nv_erase_d = (sfr_wdata == OP_ERASE);
                nv_flash_d = flash_target;
                nv_addr_d  = target_addr;
                nv_wdata_d = prog_write_data_q;
                if (sfr_wdata == OP_ERASE) begin
                    state_d = NV_ERASE;
                    cnt_d   = erase_cycles(erase_timing_q[TIM_ERASE_MSB:0]) - CNT_W'(1);
                end else begin
                    state_d = NV_PROGRAM;
                    cnt_d   = CNT_W'(PROGRAM_CYC - 1);
                end
            end
        end

        if (jump_wr) begin
            region_jump_d = sec_wdata;
            app_idx_d  = (app_nx == KEY_DONE) ? 3'h0 : app_nx;
            boot_idx_d = (boot_nx == KEY_DONE) ? 3'h0 : boot_nx;
            if (app_nx == KEY_DONE) begin
                code_offset_d = CODE_OFFSET_APP;
            end
            if (boot_nx == KEY_DONE) begin
                code_offset_d = CODE_OFFSET_BOOT;
            end
        end

        unique case (state_q)
            NV_IDLE: ;
            NV_ERASE, NV_PROGRAM: begin
                if (cnt_q == '0) begin
                    state_d = NV_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: state_d = NV_IDLE;
        endcase
    end

    // read data, one cycle after the address
    always_comb begin
        sfr_rdata_d = RST_BYTE;
        unique case (sfr_addr)
            ADDR_PROG_HIGH:    sfr_rdata_d = prog_address_high_q;
            ADDR_PROG_LOW:     sfr_rdata_d = prog_address_low_q;
            ADDR_PROG_DATA:    sfr_rdata_d = prog_write_data_q;
            ADDR_PROG_COMMAND: sfr_rdata_d = prog_command_q;
            ADDR_ERASE_TIMING: sfr_rdata_d = erase_timing_q;
            default: ;
        endcase
        sec_rdata_d = RST_BYTE;
        unique case (sec_addr)
            ADDR_UPGRADE_STATUS:   sec_rdata_d[STATUS_UPGRADE_BIT] = upgrade_q;
            ADDR_REGION_JUMP:      sec_rdata_d = region_jump_q;
            ADDR_CODE_OFFSET_LOW:  sec_rdata_d = offset_eff[7:0];
            ADDR_CODE_OFFSET_HIGH: sec_rdata_d = offset_eff[15:8];
            default: ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prog_address_high_q <= RST_BYTE;
            prog_address_low_q  <= RST_BYTE;
            prog_write_data_q   <= RST_BYTE;
            prog_command_q      <= RST_BYTE;
            erase_timing_q      <= RST_ERASE_TIMING;
            region_jump_q       <= RST_BYTE;
            upgrade_q           <= 1'b0;
            code_offset_q       <= RST_CODE_OFFSET;
            enter_idx_q         <= 3'h0;
            exit_idx_q          <= 3'h0;
            app_idx_q           <= 3'h0;
            boot_idx_q          <= 3'h0;
            state_q             <= NV_IDLE;
            cnt_q               <= '0;
            nv_start_q          <= 1'b0;
            nv_erase_q          <= 1'b0;
            nv_flash_q          <= 1'b0;
            nv_addr_q           <= 16'h0000;
            nv_wdata_q          <= RST_BYTE;
            sfr_rdata_q         <= RST_BYTE;
            sec_rdata_q         <= RST_BYTE;
            fetch_addr_q        <= 16'h0000;
        end else if (ce) begin
            prog_address_high_q <= prog_address_high_d;
            prog_address_low_q  <= prog_address_low_d;
            prog_write_data_q   <= prog_write_data_d;
            prog_command_q      <= prog_command_d;
            erase_timing_q      <= erase_timing_d;
            region_jump_q       <= region_jump_d;
            upgrade_q           <= upgrade_d;
            code_offset_q       <= code_offset_d;
            enter_idx_q         <= enter_idx_d;
            exit_idx_q          <= exit_idx_d;
            app_idx_q           <= app_idx_d;
            boot_idx_q          <= boot_idx_d;
            state_q             <= state_d;
            cnt_q               <= cnt_d;
            nv_start_q          <= nv_start_d;
            nv_erase_q          <= nv_erase_d;
            nv_flash_q          <= nv_flash_d;
            nv_addr_q           <= nv_addr_d;
            nv_wdata_q          <= nv_wdata_d;
            sfr_rdata_q         <= sfr_rdata_d;
            sec_rdata_q         <= sec_rdata_d;
            fetch_addr_q        <= fetch_addr_d;
        end
    end

    // outputs
    assign sfr_rdata  = sfr_rdata_q;
    assign sec_rdata  = sec_rdata_q;
    assign fetch_addr = fetch_addr_q;
    assign nv_start   = nv_start_q;
    assign nv_erase   = nv_erase_q;
    assign nv_flash   = nv_flash_q;
    assign nv_addr    = nv_addr_q;
    assign nv_wdata   = nv_wdata_q;
    assign nv_busy    = (state_q != NV_IDLE);
    assign sys_clk_en = (state_q == NV_IDLE);

endmodule

//--- sim/flash_iap_props.sv
// assertion checker on the flash programming controller ports
`timescale 1ns/1ns
module flash_iap_props #(
    parameter int ERASE_STEP_CYCLES = 20,
    parameter int ERASE_LONG_CYCLES = 150
) (
    // clock and reset
    input wire logic        mclk, srst, ce,
    // register ports
    input wire logic        sfr_wr, sec_wr,
    input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sec_addr, sec_wdata, sec_rdata,
    // fetch and array control
    input wire logic [1:0]  boot_sel,
    input wire logic [15:0] pc, fetch_addr, nv_addr,
    input wire logic [7:0]  nv_wdata,
    input wire logic        nv_start, nv_erase, nv_flash, nv_busy, sys_clk_en
);
    import iap_pkg::*;
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (srst);
    // busy cycles of the running operation
    always_comb begin
        cnt_d = nv_start ? 18'h1 : cnt_q + {17'h0, nv_busy};
    end
    always_ff @(posedge mclk) begin
        cnt_q <= srst ? 18'h0 : cnt_d;
    end
    a_start_one_cycle: assert property (nv_start |=> !nv_start)
        else $error("start pulse too long");
    a_start_has_cause: assert property (nv_start |-> $past(sfr_wr && sfr_addr == 8'hfc
        && (sfr_wdata == OP_ERASE || sfr_wdata == OP_PROGRAM))) else $error("stray start");
    a_erase_kind_code: assert property (nv_start |-> nv_erase == ($past(sfr_wdata) == OP_ERASE))
        else $error("operation kind wrong");
    a_clock_gated_run: assert property (nv_start |-> nv_busy && !sys_clk_en ##1 !sys_clk_en)
        else $error("clock not stopped");
    a_program_length: assert property (!$past(srst) && $fell(nv_busy) && !nv_erase |->
        cnt_q == PROGRAM_CYC) else $error("program length wrong");
    a_erase_length: assert property (!$past(srst) && $fell(nv_busy) && nv_erase |->
        cnt_q == ERASE_LONG_CYCLES || (cnt_q > ERASE_BASE_CYC && cnt_q <= ERASE_BASE_CYC
        + 10 * ERASE_STEP_CYCLES && (cnt_q - ERASE_BASE_CYC) % ERASE_STEP_CYCLES == 0))
        else $error("erase length wrong");
    a_fetch_app_offset: assert property (boot_sel == 2'h1 && $past(boot_sel) == 2'h1
        && !$past(srst) |-> fetch_addr == $past(pc) + 16'h1000) else $error("fetch address wrong");
    a_jump_readback: assert property (sec_wr && sec_addr == 8'h22 ##1 sec_addr == 8'h22
        |=> sec_rdata == $past(sec_wdata, 2)) else $error("jump register readback wrong");
endmodule

//--- sim/cpu_fw_model.sv
// processor core model issuing firmware register accesses
`timescale 1ns/1ns
module cpu_fw_model (
    // clock and gate
    input  wire logic       mclk,
    input  wire logic       sys_clk_en,
    // register ports
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata,
    output logic      [7:0] sec_addr,
    output logic            sec_wr,
    output logic      [7:0] sec_wdata,
    input  wire logic [7:0] sec_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sec_addr = 8'h00;
        sfr_wr = 1'b0;
        sec_wr = 1'b0;
        sfr_wdata = 8'h00;
        sec_wdata = 8'h00;
    end
    // core is frozen while its clock is gated off
    task automatic sync();
        @(negedge mclk);
        while (sys_clk_en !== 1'b1) begin
            @(negedge mclk);
        end
    endtask
    task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] d);
        sync();
        sfr_addr = a;
        sec_addr = a;
        sfr_wdata = d;
        sec_wdata = d;
        sfr_wr = !sec;
        sec_wr = sec;
        @(negedge mclk);
        sfr_wr = 1'b0;
        sec_wr = 1'b0;
        sfr_wdata = ~d;
        sec_wdata = ~d;
    endtask
    task automatic rd(input logic sec, input logic [7:0] a, output logic [7:0] d);
        sync();
        sfr_addr = a;
        sec_addr = a;
        @(negedge mclk);
        d = sec ? sec_rdata : sfr_rdata;
    endtask
    // interrupts stay masked: the model raises none
    task automatic setup(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d);
        wr(1'b0, 8'hfa, lo);
        wr(1'b0, 8'hf9, hi);
        wr(1'b0, 8'hfb, d);
    endtask
    task automatic nops(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic restore();
        wr(1'b0, 8'hf9, 8'h00);
        wr(1'b0, 8'hfa, 8'h00);
    endtask
endmodule

//--- sim/test_flash_iap_boot_upgrade_ctrl.sv
// self-checking bench for the flash programming controller
`timescale 1ns/1ns
module test_flash_iap_boot_upgrade_ctrl;
    import iap_pkg::*;
    localparam int ERASE_STEP_CYCLES = 20;
    localparam int ERASE_LONG_CYCLES = 150;
    logic        mclk, srst, sfr_wr, sec_wr, nv_start, nv_erase, nv_flash, nv_busy, sys_clk_en;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sec_addr, sec_wdata, sec_rdata, nv_wdata, rv;
    logic [1:0]  boot_sel;
    logic [15:0] pc, fetch_addr, nv_addr;
    int          err_count, samples_checked, cycles;
    logic [16:0] tab [11] = '{17'h0_f900, 17'h0_fa00, 17'h0_fb00, 17'h0_fc00, 17'h0_fd5a,
        17'h1_2100, 17'h1_2200, 17'h1_2300, 17'h1_2400, 17'h0_8000, 17'h1_3000};
    logic [4:0]  sels [3] = '{5'h00, 5'h09, 5'h0a};
    flash_iap_boot_upgrade_ctrl #(.ERASE_STEP_CYCLES(ERASE_STEP_CYCLES),
        .ERASE_LONG_CYCLES(ERASE_LONG_CYCLES)) dut (.mclk(mclk), .srst(srst), .ce(1'b1),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sec_addr(sec_addr), .sec_wr(sec_wr), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata),
        .boot_sel(boot_sel), .pc(pc), .fetch_addr(fetch_addr), .nv_start(nv_start),
        .nv_erase(nv_erase), .nv_flash(nv_flash), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .nv_busy(nv_busy), .sys_clk_en(sys_clk_en));
    cpu_fw_model cpu (.mclk(mclk), .sys_clk_en(sys_clk_en), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sec_addr(sec_addr),
        .sec_wr(sec_wr), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata));
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic sec, input logic [7:0] a, input logic [7:0] exp);
        cpu.rd(sec, a, rv);
        chk({8'h00, rv}, {8'h00, exp});
    endtask
    task automatic key(input logic sec, input logic [39:0] k);
        for (int i = 0; i < 5; i++) cpu.wr(sec, sec ? 8'h22 : 8'hfc, k[39-8*i -: 8]);
    endtask
    task automatic op(input logic [7:0] hi, lo, d, c, input int len, input logic fl,
                      input logic [15:0] a);
        int n;
        cpu.setup(hi, lo, d);
        rdchk(1'b0, 8'hfb, d);
        cpu.wr(1'b0, 8'hfc, c);
        n = 0;
        chk({15'h0, nv_start}, {15'h0, len > 0});
        if (len > 0) begin
            chk({nv_erase, nv_flash, 14'h0}, {c == OP_ERASE, fl, 14'h0});
            chk(nv_addr, a);
            chk({8'h00, nv_wdata}, {8'h00, d});
        end
        while (nv_busy === 1'b1 && n < 5000) begin
            n++;
            @(negedge mclk);
        end
        chk(n[15:0], len[15:0]);
        chk({15'h0, sys_clk_en}, 16'h0001);
        cpu.nops(4);
        cpu.restore();
    endtask
    initial begin
        srst = 1'b1;
        boot_sel = 2'h0;
        pc = 16'h0100;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        foreach (tab[i]) rdchk(tab[i][16], tab[i][15:8], tab[i][7:0]);
        for (int i = 5; i < 11; i++) cpu.wr(tab[i][16], tab[i][15:8], i == 6 ? 8'h00 : 8'hff);
        for (int i = 5; i < 11; i++) rdchk(tab[i][16], tab[i][15:8], tab[i][7:0]);
        op(8'h05, 8'h34, 8'ha5, OP_PROGRAM, PROGRAM_CYC, 1'b0, 16'h8734);
        foreach (sels[i]) begin
            cpu.wr(1'b0, 8'hfd, {3'h7, sels[i]});
            op(8'h00, 8'h00, 8'h00, OP_ERASE, sels[i] > 9 ? ERASE_LONG_CYCLES :
                ERASE_BASE_CYC + (sels[i] + 1) * ERASE_STEP_CYCLES, 1'b0, 16'h8400);
        end
        boot_sel = 2'h3;
        key(1'b0, KEY_ENTER);
        rdchk(1'b1, 8'h21, 8'h00);
        boot_sel = 2'h0;
        pc = 16'h2000;
        key(1'b0, KEY_ENTER);
        rdchk(1'b1, 8'h21, 8'h00);
        pc = 16'h0100;
        key(1'b0, KEY_ENTER);
        rdchk(1'b1, 8'h21, 8'h01);
        key(1'b0, 40'hfe_dcba_0098);
        cpu.wr(1'b0, 8'hfc, 8'h76);
        rdchk(1'b1, 8'h21, 8'h01);
        op(8'h10, 8'h20, 8'h3c, OP_PROGRAM, PROGRAM_CYC, 1'b1, 16'h1020);
        op(8'h84, 8'h01, 8'h77, OP_PROGRAM, PROGRAM_CYC, 1'b0, 16'h8601);
        op(8'h7e, 8'h00, 8'h00, OP_ERASE, ERASE_LONG_CYCLES, 1'b1, 16'h7e00);
        op(8'h08, 8'h00, 8'h00, OP_ERASE, 0, 1'b1, 16'h0800);
        key(1'b0, KEY_EXIT);
        rdchk(1'b1, 8'h21, 8'h00);
        key(1'b1, KEY_TO_APP);
        rdchk(1'b1, 8'h22, 8'haa);
        rdchk(1'b1, 8'h24, 8'h10);
        rdchk(1'b1, 8'h23, 8'h00);
        chk(fetch_addr, 16'h1100);
        key(1'b1, KEY_TO_BOOT);
        rdchk(1'b1, 8'h22, 8'h65);
        rdchk(1'b1, 8'h24, 8'h00);
        chk(fetch_addr, 16'h0100);
        boot_sel = 2'h1;
        rdchk(1'b1, 8'h24, 8'h10);
        chk(fetch_addr, 16'h1100);
        report_and_stop();
    end
endmodule
bind flash_iap_boot_upgrade_ctrl flash_iap_props #(.ERASE_STEP_CYCLES(ERASE_STEP_CYCLES),
    .ERASE_LONG_CYCLES(ERASE_LONG_CYCLES)) props (.mclk(mclk), .srst(srst), .ce(ce),
    .sfr_wr(sfr_wr), .sec_wr(sec_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sec_addr(sec_addr), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata),
    .boot_sel(boot_sel), .pc(pc), .fetch_addr(fetch_addr), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_start(nv_start), .nv_erase(nv_erase), .nv_flash(nv_flash),
    .nv_busy(nv_busy), .sys_clk_en(sys_clk_en));
